// ### verilog/pbs_pkg.sv
// Shared constants and types for the pipelined burst static memory port.
// Assumes a single clock shared with the controller on the far side.
package pbs_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DEPTH = 131072;
  localparam int BURST_LEN = 4;
  localparam int PIPE_DEPTH = 2;
  localparam logic [1:0] BURST_CNT_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [LANES-1:0] BW_RST = 4'hf;
  typedef enum logic [2:0] {
    PBS_IDLE = 3'b001,
    PBS_READ = 3'b010,
    PBS_WRITE = 3'b100
  } pbs_op_t;
endpackage

// ### verilog/pbs_mem.sv
// Word memory with per-lane write enables, separate read and write addresses
// and a registered read port.
// Assumes the caller gates both write and read with its own advance strobe.
`timescale 1ns/1ps
module pbs_mem #(
  parameter int AW = 17,
  parameter int LN = 4,
  parameter int LW = 9
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [AW-1:0] rd_addr,
  input wire logic [LN-1:0] lane_we,
  input wire logic [LN*LW-1:0] wdata,
  output logic [LN*LW-1:0] rdata
);
  logic [LN*LW-1:0] mem [0:(2**AW)-1];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int i = 0; i < LN; i++) begin
        if (lane_we[i]) begin
          mem[wr_addr][i*LW +: LW] <= wdata[i*LW +: LW];
        end
      end
    end
    // A write can land on the same edge that a later read samples the array.
    // Forwarding its lanes keeps a read right behind a write from seeing stale data.
    if (rd_en) begin
      for (int j = 0; j < LN; j++) begin
        if (wr_en && lane_we[j] && (wr_addr == rd_addr)) begin
          rdata[j*LW +: LW] <= wdata[j*LW +: LW];
        end else begin
          rdata[j*LW +: LW] <= mem[rd_addr][j*LW +: LW];
        end
      end
    end
  end
endmodule

// ### verilog/pbs_port.sv
// Synchronous pipelined burst memory port with clock-enable stall.
// Assumes the controller shares sys_clk; the tristate wire is resolved outside.
//
// Summary of operation
// - Data moves two enabled cycles after capture.
// - Reads and writes mix with no idle cycles.
// - 128K words of 36 bits, 17-bit address.
// - Clock enable high freezes all state.
// - Address captured on load, enabled, selected.
// - Deselect starts nothing, pipeline still finishes.
// - Bus floats two cycles after deselect or write.
// - Load takes new address; advance steps counter.
// - Advance ignores external address, continues burst.
// - Load while deselected ends any burst.
// - Four-word burst, linear or interleaved order.
// - Read/write sampled at load picks direction.
// - Output enable high floats outputs immediately.
// - Per-lane write enables, applied two cycles later.
// - Order input high interleaved, low linear.
// - Selected when both low enables low, high high.
`timescale 1ns/1ps
module pbs_port #(
  parameter int ADDR_W = pbs_pkg::ADDR_W,
  parameter int LANES = pbs_pkg::LANES,
  parameter int LANE_W = pbs_pkg::LANE_W
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clock_enable_n,
  input wire logic chip_select_low_a,
  input wire logic chip_select_low_b,
  input wire logic chip_select_high,
  input wire logic advance_or_load,
  input wire logic read_not_write,
  input wire logic burst_order_select,
  input wire logic [LANES-1:0] byte_write_n,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic output_enable_n,
  input wire logic [31:0] data_bus_main_in,
  input wire logic [3:0] data_bus_parity_in,
  output logic [31:0] data_bus_main_out,
  output logic [3:0] data_bus_parity_out,
  output logic data_bus_oe_n
);
  import pbs_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Pins are synchronous to sys_clk, so they are not resynchronised.
  typedef struct packed {
    logic burst_on;
    logic order;
    logic [ADDR_W-1:0] base;
    logic [1:0] cnt;
    pbs_op_t op;
    logic [LANES-1:0] bw;
    pbs_op_t op1;
    logic [ADDR_W-1:0] a1;
    logic [LANES-1:0] bw1;
    pbs_op_t op2;
    logic [ADDR_W-1:0] a2;
    logic [LANES-1:0] bw2;
    logic drive;
  } pbs_state_t;

  pbs_state_t s_q;
  pbs_state_t s_d;
  logic adv;
  logic sel;
  logic [1:0] low_bits;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] wdata;

  assign adv = ~clock_enable_n;
  assign sel = ~chip_select_low_a & ~chip_select_low_b & chip_select_high;
  assign wdata = {data_bus_parity_in, data_bus_main_in};

  // ----------------------------------------
  // Control pipeline and burst counter
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    low_bits = 2'h0;
    cur_addr = s_q.a1;
    if (adv) begin
      s_d.op2 = s_q.op1;
      s_d.a2 = s_q.a1;
      s_d.bw2 = s_q.bw1;
      s_d.drive = (s_q.op1 == PBS_READ);
      if (!advance_or_load) begin
        if (sel) begin
          s_d.burst_on = 1'b1;
          s_d.order = burst_order_select;
          s_d.base = addr_in;
          s_d.cnt = BURST_CNT_RST;
          s_d.op = read_not_write ? PBS_READ : PBS_WRITE;
          s_d.bw = ~byte_write_n;
          s_d.op1 = s_d.op;
          s_d.a1 = addr_in;
          s_d.bw1 = s_d.bw;
        end else begin
          s_d.burst_on = 1'b0;
          s_d.op1 = PBS_IDLE;
        end
      end else if (s_q.burst_on) begin
        s_d.cnt = s_q.cnt + 2'h1;
        // Interleaved order XORs the count; linear adds it.
        low_bits = s_q.order ? (s_q.base[1:0] ^ s_d.cnt) : (s_q.base[1:0] + s_d.cnt);
        s_d.a1 = {s_q.base[ADDR_W-1:2], low_bits};
        s_d.op1 = s_q.op;
        s_d.bw1 = (s_q.op == PBS_WRITE) ? ~byte_write_n : '0;
      end else begin
        s_d.op1 = PBS_IDLE;
      end
    end
    cur_addr = s_q.a2;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{burst_on: 1'b0, order: 1'b0, base: ADDR_RST, cnt: BURST_CNT_RST,
               op: PBS_IDLE, bw: '0, op1: PBS_IDLE, a1: ADDR_RST, bw1: '0,
               op2: PBS_IDLE, a2: ADDR_RST, bw2: '0, drive: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Array access
  // ----------------------------------------
  // The read is issued one stage early so the registered word lands on the bus
  // exactly one enabled edge after capture.
  logic mem_wr;
  logic mem_rd;
  assign mem_wr = adv & (s_q.op2 == PBS_WRITE);
  assign mem_rd = adv & (s_q.op1 == PBS_READ);

  pbs_mem #(.AW(ADDR_W), .LN(LANES), .LW(LANE_W)) u_mem (
    .clk(sys_clk),
    .wr_en(mem_wr),
    .rd_en(mem_rd),
    .wr_addr(cur_addr),
    .rd_addr(s_q.a1),
    .lane_we(s_q.bw2),
    .wdata(wdata),
    .rdata(rdata)
  );

  // Output enable is combinational so it floats the bus at once.
  assign data_bus_oe_n = ~s_q.drive | output_enable_n;
  assign data_bus_main_out = rdata[31:0];
  assign data_bus_parity_out = rdata[35:32];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_read_drives;
    @(posedge sys_clk) disable iff (!rst_b)
      (adv && !advance_or_load && sel && read_not_write) ##1 adv[*1] ##0 1'b1 |->
        ##1 s_q.drive;
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("Read did not drive bus");

  property p_write_floats;
    @(posedge sys_clk) disable iff (!rst_b)
      (adv && !advance_or_load && sel && !read_not_write) ##1 adv |-> ##1 !s_q.drive;
  endproperty
  a_write_floats: assert property (p_write_floats) else $error("Write left bus driven");

  property p_desel_floats;
    @(posedge sys_clk) disable iff (!rst_b)
      (adv && !advance_or_load && !sel) ##1 adv |-> ##1 data_bus_oe_n;
  endproperty
  a_desel_floats: assert property (p_desel_floats) else $error("Deselect left bus driven");

  property p_stall_holds;
    @(posedge sys_clk) disable iff (!rst_b)
      !adv |=> (s_q == $past(s_q));
  endproperty
  a_stall_holds: assert property (p_stall_holds) else $error("State moved while stalled");

  property p_oe_async;
    @(posedge sys_clk) disable iff (!rst_b)
      output_enable_n |-> data_bus_oe_n;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("Bus driven with output off");

  property p_load_addr;
    @(posedge sys_clk) disable iff (!rst_b)
      (adv && !advance_or_load && sel) |=> (s_q.a1 == $past(addr_in));
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("Address not captured");

  property p_desel_ends;
    @(posedge sys_clk) disable iff (!rst_b)
      (adv && !advance_or_load && !sel) |=> !s_q.burst_on && s_q.op1 == PBS_IDLE;
  endproperty
  a_desel_ends: assert property (p_desel_ends) else $error("Burst survived deselect");

  property p_upper_fixed;
    @(posedge sys_clk) disable iff (!rst_b)
      (adv && advance_or_load && s_q.burst_on) |=>
        s_q.a1[ADDR_W-1:2] == s_q.base[ADDR_W-1:2];
  endproperty
  a_upper_fixed: assert property (p_upper_fixed) else $error("Burst changed high bits");

  property p_pipe_shift;
    @(posedge sys_clk) disable iff (!rst_b)
      adv |=> (s_q.a2 == $past(s_q.a1)) && (s_q.op2 == $past(s_q.op1));
  endproperty
  a_pipe_shift: assert property (p_pipe_shift) else $error("Pipeline did not shift");

  property p_dir_capture;
    @(posedge sys_clk) disable iff (!rst_b)
      (adv && !advance_or_load && sel) |=>
        s_q.op1 == ($past(read_not_write) ? PBS_READ : PBS_WRITE);
  endproperty
  a_dir_capture: assert property (p_dir_capture) else $error("Direction not captured");

  property p_cnt_step;
    @(posedge sys_clk) disable iff (!rst_b)
      (adv && advance_or_load && s_q.burst_on) |=> s_q.cnt == $past(s_q.cnt) + 2'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("Burst counter did not step");
endmodule

// ### sim/pbs_ctrl_model.sv
// Controller-side model that drives write data onto the shared bus.
// Assumes the bench flags every write load and burst-write cycle on wr_issue.
`timescale 1ns/1ps
module pbs_ctrl_model (
  input wire logic sys_clk,
  input wire logic clock_enable_n,
  input wire logic wr_issue,
  input wire logic [35:0] wr_word,
  input wire logic [35:0] dev_word,
  input wire logic dev_oe_n,
  output logic [35:0] bus_word
);
  logic [1:0] v_q;
  logic [35:0] w1_q;
  logic [35:0] w2_q;
  logic [35:0] last_q;
  initial v_q = 2'h0;
  always @(posedge sys_clk) begin
    last_q <= bus_word;
    if (!clock_enable_n) begin
      v_q <= {v_q[0], wr_issue};
      w1_q <= wr_word;
      w2_q <= w1_q;
    end
  end
  // Two drivers at once give an unknown; a released wire flips its last level.
  assign bus_word = (v_q[1] && !dev_oe_n) ? 'x : v_q[1] ? w2_q : !dev_oe_n ? dev_word : ~last_q;
endmodule

// ### sim/pbs_port_bench.sv
// Self-checking bench for the pipelined burst memory port.
// Assumes the controller model supplies all write data on the bus.
`timescale 1ns/1ps
module pbs_port_bench;
  import pbs_pkg::*;
  localparam logic [2:0] ON = 3'b001;
  localparam logic [35:0] W1 = 36'h123456789;
  localparam logic [35:0] W2 = 36'hfedcba987;
  localparam logic [35:0] M = {9'h0, 9'h1ff, 9'h0, 9'h1ff};
  logic sys_clk, rst_b, ck_en_n, adv, rnw, ord, oen, wr_issue, dev_oe_n;
  logic [2:0] sel;
  logic [3:0] bw;
  logic [16:0] a;
  logic [35:0] wr_word, dev_word, bus;
  int mismatches, total_checks;
  pbs_port i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clock_enable_n(ck_en_n),
    .chip_select_low_a(sel[2]), .chip_select_low_b(sel[1]), .chip_select_high(sel[0]),
    .advance_or_load(adv), .read_not_write(rnw), .burst_order_select(ord),
    .byte_write_n(bw), .addr_in(a), .output_enable_n(oen),
    .data_bus_main_in(bus[31:0]), .data_bus_parity_in(bus[35:32]),
    .data_bus_main_out(dev_word[31:0]), .data_bus_parity_out(dev_word[35:32]),
    .data_bus_oe_n(dev_oe_n));
  pbs_ctrl_model i_ctrl (.sys_clk(sys_clk), .clock_enable_n(ck_en_n), .wr_issue(wr_issue),
    .wr_word(wr_word), .dev_word(dev_word), .dev_oe_n(dev_oe_n), .bus_word(bus));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [35:0] f(input logic [16:0] x);
    f = {3'h5, x, x[15:0] ^ 16'h3c3c};
  endfunction
  function automatic logic [16:0] ba(input logic [16:0] b, input logic o, input int k);
    logic [1:0] kk;
    kk = k[1:0];
    ba = {b[16:2], o ? b[1:0] ^ kk : b[1:0] + kk};
  endfunction
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic oe(input logic e);
    cmp({35'h0, dev_oe_n}, {35'h0, e});
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One cycle of inputs, applied at a falling edge, held to the next one.
  task automatic go(input logic c, input logic l, input logic r, input logic [2:0] s,
      input logic [16:0] x, input logic [3:0] b, input logic [35:0] w);
    ck_en_n = c;
    adv = l;
    rnw = r;
    sel = s;
    a = x;
    bw = b;
    wr_word = w;
    wr_issue = !c && !r && (l || s == ON);
    @(negedge sys_clk);
  endtask
  task automatic ds(input logic [2:0] s);
    go(0, 0, 1, s, 17'h0, 4'hf, '0);
  endtask
  task automatic t_mix();
    go(0, 0, 0, ON, 17'h1fffe, 4'h0, W1);
    go(0, 0, 0, ON, 17'h1fffe, 4'ha, W2);
    go(0, 0, 1, ON, 17'h1fffe, 4'h0, '0);
    ds(3'b101);
    cmp(dev_word, (W2 & M) | (W1 & ~M));
    oe(1'b0);
    ds(3'b011);
    go(0, 0, 0, ON, 17'h00001, 4'h0, f(17'h1));
    oe(1'b1);
    go(0, 0, 1, ON, 17'h00001, 4'h0, '0);
    oe(1'b1);
    ds(3'b000);
    cmp(dev_word, f(17'h1));
    oen = 1'b1;
    #1 oe(1'b1);
    @(negedge sys_clk);
    oen = 1'b0;
  endtask
  task automatic t_burst(input logic o, input logic r, input logic [16:0] b);
    ord = o;
    for (int i = 0; i < 6; i++) begin
      if (i < 4) go(0, i != 0, r, ON, i == 0 ? b : ~b, 4'h0, f(ba(b, o, i)));
      else ds(3'b000);
      if (r && i > 0 && i < 5) cmp(dev_word, f(ba(b, o, i - 1)));
    end
  endtask
  task automatic t_stall();
    go(0, 0, 1, ON, 17'h00a40, 4'h0, '0);
    go(1, 0, 0, ON, 17'h00a41, 4'h0, '0);
    oe(1'b1);
    ds(3'b101);
    cmp(dev_word, f(17'h00a40));
    go(0, 0, 1, ON, 17'h00a41, 4'h0, '0);
    go(1, 0, 0, ON, 17'h00a43, 4'h0, '0);
    cmp(dev_word, f(17'h00a40));
  endtask
  task automatic t_end();
    go(0, 0, 1, ON, 17'h00a40, 4'h0, '0);
    ds(3'b000);
    cmp(dev_word, f(17'h00a40));
    go(0, 1, 1, ON, 17'h00a42, 4'h0, '0);
    go(0, 1, 1, ON, 17'h00a43, 4'h0, '0);
    oe(1'b1);
    go(0, 1, 1, ON, 17'h00a41, 4'h0, '0);
    oe(1'b1);
  endtask
  initial begin
    #5000;
    mismatches++;
    give_verdict();
  end
  initial begin
    rst_b = 1'b0;
    ck_en_n = 1'b0;
    adv = 1'b0;
    rnw = 1'b1;
    ord = 1'b0;
    oen = 1'b0;
    sel = 3'b101;
    bw = 4'hf;
    a = '0;
    wr_issue = 1'b0;
    wr_word = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    oe(1'b1);
    rst_b = 1'b1;
    t_mix();
    t_burst(1'b0, 1'b0, 17'h00a41);
    t_burst(1'b1, 1'b1, 17'h00a42);
    t_burst(1'b0, 1'b1, 17'h00a43);
    t_stall();
    t_end();
    give_verdict();
  end
endmodule
